//--- cmad_decode.sv
// Operand address decoder: picks the memory space for each operand
`timescale 1ns/1ps
`include "cmad_defs.svh"

module cmad_decode
    import cmad_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input cmad_req_t req,
    output cmad_resp_t resp_q,
    output logic resp_valid_q
);

    cmad_resp_t resp_d;
    logic resp_valid_d;
    logic is_ext_mode;
    logic is_ext_class;
    logic is_code_mode;
    logic is_code_class;
    logic bad;
    logic [15:0] code_base;
    logic [15:0] code_sum;
    logic [15:0] flash_addr;

    // Flash address for code reads: table base plus accumulator index
    always_comb begin
        code_base = req.base_pc ? req.pc : req.data_pointer_reg;
        code_sum = code_base + {8'h00, req.acc};
        if (req.mode == MD_IMMEDIATE) begin
            flash_addr = req.pc;
        end else begin
            flash_addr = code_sum;
        end
    end

    // Mode and class pairing checks
    always_comb begin
        is_ext_mode = (req.mode == MD_EXT_DIRECT)
            || (req.mode == MD_EXT_INDIRECT);
        is_ext_class = (req.iclass == IC_EXT_MOVE);
        is_code_mode = (req.mode == MD_CODE_INDIRECT);
        is_code_class = (req.iclass == IC_CODE_MOVE);
        bad = 1'b0;
        // Extended RAM only with the extended move class
        if (is_ext_mode != is_ext_class) begin
            bad = 1'b1;
        end
        // Constant reads only by the code move class
        if (is_code_mode != is_code_class) begin
            bad = 1'b1;
        end
        // Bit operands are always given as a direct bit address
        if (req.iclass == IC_BOOLEAN && req.mode != MD_DIRECT) begin
            bad = 1'b1;
        end
        // Flash is never written through an operand
        if (req.write && (req.mode == MD_IMMEDIATE || is_code_mode)) begin
            bad = 1'b1;
        end
        // Nothing past the end of on-chip flash is fetched
        if ((req.mode == MD_IMMEDIATE || is_code_mode)
                && {1'b0, flash_addr} >= `CMAD_FLASH_TOP) begin
            bad = 1'b1;
        end
    end

    // Space and address selection for each addressing mode
    always_comb begin
        resp_d = '0;
        resp_valid_d = req_valid;
        resp_d.write = req.write;
        resp_d.wdata = req.wdata;
        if (req_valid) begin
            case (req.mode)
                MD_IMMEDIATE: begin
                    // Literal follows the opcode in program memory
                    resp_d.space = SP_FLASH;
                    resp_d.addr = flash_addr;
                end
                MD_DIRECT: begin
                    if (req.iclass == IC_BOOLEAN) begin
                        resp_d.bit_en = 1'b1;
                        resp_d.bit_sel = req.addr[2:0];
                        if (req.addr[7]) begin
                            // Upper bit addresses hit registers at x0/x8
                            resp_d.space = SP_SPECIAL;
                            resp_d.addr = {8'h00, req.addr[7:3], 3'b000};
                        end else begin
                            // Lower bit addresses hit RAM 0x20-0x2F
                            resp_d.space = SP_LOW_RAM;
                            resp_d.addr = {8'h00, `CMAD_BIT_RAM_BASE
                                | {4'h0, req.addr[6:3]}};
                        end
                    end else if (req.addr >= `CMAD_UPPER_BASE) begin
                        resp_d.space = SP_SPECIAL;
                        resp_d.addr = {8'h00, req.addr};
                    end else begin
                        resp_d.space = SP_LOW_RAM;
                        resp_d.addr = {8'h00, req.addr};
                    end
                end
                MD_INDIRECT: begin
                    // Pointer contents name the RAM byte, never a register
                    resp_d.addr = {8'h00, req.pointer_register_zero};
                    if (req.pointer_register_zero >= `CMAD_UPPER_BASE) begin
                        resp_d.space = SP_UPPER_RAM;
                    end else begin
                        resp_d.space = SP_LOW_RAM;
                    end
                end
                MD_EXT_DIRECT: begin
                    // Upper pointer bits dropped, always on-chip
                    resp_d.space = SP_EXT_RAM;
                    resp_d.addr = {5'h00,
                        req.data_pointer_reg[`CMAD_EXT_AW-1:0]};
                end
                MD_EXT_INDIRECT: begin
                    resp_d.space = SP_EXT_RAM;
                    resp_d.addr = {8'h00, req.pointer_register_zero};
                end
                MD_CODE_INDIRECT: begin
                    resp_d.space = SP_FLASH;
                    resp_d.addr = flash_addr;
                end
                default: begin
                    // Codes beyond the six modes are refused
                    resp_d.err = 1'b1;
                end
            endcase
            // Refused requests leave every memory untouched
            if (bad || resp_d.err) begin
                resp_d.space = SP_NONE;
                resp_d.addr = 16'h0000;
                resp_d.bit_en = 1'b0;
                resp_d.bit_sel = 3'h0;
                resp_d.write = 1'b0;
                resp_d.err = 1'b1;
            end
        end else begin
            resp_d.write = 1'b0;
            resp_d.wdata = 8'h00;
        end
    end

    // Decoded access registered toward the memories
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resp_q <= '0;
            resp_valid_q <= 1'b0;
        end else begin
            resp_q <= resp_d;
            resp_valid_q <= resp_valid_d;
        end
    end

    // Checks on the decoded access
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_direct_upper_special: assert property (
        req_valid && req.mode == MD_DIRECT && req.iclass == IC_GENERAL
        && req.addr[7]
        |=> resp_q.space == SP_SPECIAL
        && resp_q.addr == {8'h00, $past(req.addr)})
    else $error("direct upper address not routed to registers");

    a_special_only_direct: assert property (
        resp_valid_q && resp_q.space == SP_SPECIAL
        |-> $past(req.mode) == MD_DIRECT && resp_q.addr[7])
    else $error("register space reached by a non-direct mode");

    a_indirect_upper_ram: assert property (
        req_valid && req.mode == MD_INDIRECT && req.iclass == IC_GENERAL
        && req.pointer_register_zero[7]
        |=> resp_q.space == SP_UPPER_RAM && !resp_q.err)
    else $error("indirect upper address not routed to upper RAM");

    a_low_ram_shared: assert property (
        resp_valid_q && resp_q.space == SP_LOW_RAM && !resp_q.bit_en
        |-> resp_q.addr < {8'h00, `CMAD_UPPER_BASE}
        && resp_q.addr[7:0] == ($past(req.mode) == MD_DIRECT
        ? $past(req.addr) : $past(req.pointer_register_zero)))
    else $error("low RAM address differs from operand");

    a_indirect_pointer: assert property (
        req_valid && req.mode == MD_INDIRECT && req.iclass != IC_BOOLEAN
        && !(req.write && 1'b0)
        |=> resp_q.addr[7:0] == $past(req.pointer_register_zero)
        ##1 1'b1)
    else $error("indirect address not taken from pointer");

    a_ext_direct_addr: assert property (
        req_valid && req.mode == MD_EXT_DIRECT
        && req.iclass == IC_EXT_MOVE
        |=> resp_q.space == SP_EXT_RAM
        && resp_q.addr == {5'h00, $past(req.data_pointer_reg[10:0])})
    else $error("extended direct address not from data pointer");

    a_ext_indirect_addr: assert property (
        req_valid && req.mode == MD_EXT_INDIRECT
        && req.iclass == IC_EXT_MOVE
        |=> resp_q.space == SP_EXT_RAM
        && resp_q.addr == {8'h00, $past(req.pointer_register_zero)})
    else $error("extended indirect address not from register");

    a_ext_class_only: assert property (
        resp_valid_q && resp_q.space == SP_EXT_RAM
        |-> $past(req.iclass) == IC_EXT_MOVE
        && resp_q.addr < `CMAD_EXT_TOP)
    else $error("extended RAM reached by another class");

    a_code_sum_addr: assert property (
        req_valid && req.mode == MD_CODE_INDIRECT
        && req.iclass == IC_CODE_MOVE && !req.write
        && {1'b0, code_sum} < `CMAD_FLASH_TOP
        |=> resp_q.space == SP_FLASH && resp_q.addr == $past(code_sum))
    else $error("code read address is not base plus index");

    a_flash_in_range: assert property (
        resp_valid_q && resp_q.space == SP_FLASH
        |-> {1'b0, resp_q.addr} < `CMAD_FLASH_TOP && !resp_q.write)
    else $error("flash access outside on-chip space");

    a_immediate_pc: assert property (
        req_valid && req.mode == MD_IMMEDIATE && req.iclass == IC_GENERAL
        && !req.write && {1'b0, req.pc} < `CMAD_FLASH_TOP
        |=> resp_q.space == SP_FLASH && resp_q.addr == $past(req.pc))
    else $error("immediate literal not fetched at program counter");

    a_bad_mode_err: assert property (
        req_valid && req.mode > MD_CODE_INDIRECT
        |=> resp_q.err && resp_q.space == SP_NONE && !resp_q.write)
    else $error("unknown mode not refused");

    a_bit_special: assert property (
        req_valid && req.iclass == IC_BOOLEAN && req.mode == MD_DIRECT
        |=> resp_q.bit_en && resp_q.bit_sel == $past(req.addr[2:0])
        && (resp_q.space == SP_SPECIAL) == $past(req.addr[7]))
    else $error("bit operand decoded wrongly");

endmodule // cmad_decode

//--- cmad_defs.svh
// Address map and field constants for the operand address decoder
`ifndef CMAD_DEFS_SVH
`define CMAD_DEFS_SVH

// Internal RAM split: below this direct and indirect share locations
`define CMAD_UPPER_BASE 8'h80
// First byte of the bit-addressable internal RAM area
`define CMAD_BIT_RAM_BASE 8'h20
// Extended RAM: 2 kB, 11 address bits
`define CMAD_EXT_AW 11
`define CMAD_EXT_TOP 16'h0800
// On-chip flash: 62 kB, first address past the end
`define CMAD_FLASH_TOP 17'h0f800

`endif

//--- cmad_pkg.sv
// Types shared by the operand address decoder and its users
package cmad_pkg;

    // Operand addressing modes, binary codes written out
    typedef enum logic [2:0] {
        MD_IMMEDIATE = 3'b000,
        MD_DIRECT = 3'b001,
        MD_INDIRECT = 3'b010,
        MD_EXT_DIRECT = 3'b011,
        MD_EXT_INDIRECT = 3'b100,
        MD_CODE_INDIRECT = 3'b101
    } cmad_mode_t;

    // Instruction class that issues the operand request
    typedef enum logic [1:0] {
        IC_GENERAL = 2'b00,
        IC_BOOLEAN = 2'b01,
        IC_EXT_MOVE = 2'b10,
        IC_CODE_MOVE = 2'b11
    } cmad_iclass_t;

    // Memory space chosen for the access
    typedef enum logic [2:0] {
        SP_NONE = 3'b000,
        SP_LOW_RAM = 3'b001,
        SP_UPPER_RAM = 3'b010,
        SP_SPECIAL = 3'b011,
        SP_EXT_RAM = 3'b100,
        SP_FLASH = 3'b101
    } cmad_space_t;

    // Operand request from the execution logic
    typedef struct packed {
        cmad_mode_t mode;
        cmad_iclass_t iclass;
        logic [7:0] addr;
        logic [7:0] pointer_register_zero;
        logic [15:0] data_pointer_reg;
        logic [7:0] acc;
        logic [15:0] pc;
        logic base_pc;
        logic write;
        logic [7:0] wdata;
    } cmad_req_t;

    // Decoded access toward the memories and register space
    typedef struct packed {
        cmad_space_t space;
        logic [15:0] addr;
        logic bit_en;
        logic [2:0] bit_sel;
        logic write;
        logic [7:0] wdata;
        logic err;
    } cmad_resp_t;

endpackage

//--- cmad_mem_model.sv
// Memory side model: counts decoded accesses, flags any leaving the chip
`timescale 1ns/1ps
`include "cmad_defs.svh"

module cmad_mem_model
    import cmad_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic resp_valid_q,
    input cmad_resp_t resp_q,
    output int bad_cnt,
    output int hit_cnt
);
    initial bad_cnt = 0;
    initial hit_cnt = 0;

    // Accepted access must land in an on-chip space within its size
    always @(posedge clk) begin
        if (reset_n && resp_valid_q && !resp_q.err) begin
            hit_cnt <= hit_cnt + 1;
            if (resp_q.space == SP_NONE) begin
                bad_cnt <= bad_cnt + 1;
            end
            if (resp_q.space == SP_EXT_RAM &&
                resp_q.addr >= `CMAD_EXT_TOP) begin
                bad_cnt <= bad_cnt + 1;
            end
            if (resp_q.space == SP_FLASH &&
                {1'b0, resp_q.addr} >= `CMAD_FLASH_TOP) begin
                bad_cnt <= bad_cnt + 1;
            end
        end
    end
endmodule // cmad_mem_model

//--- core_memory_address_decode_tb.sv
// Self-checking bench for the operand address decoder
`timescale 1ns/1ps

module core_memory_address_decode_tb
    import cmad_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    cmad_req_t req = '0;
    cmad_resp_t resp_q;
    logic resp_valid_q;
    cmad_resp_t exp_q = '0;
    logic expv_q = 1'b0;
    int bad_cnt;
    int hit_cnt;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 60589;

    cmad_decode uut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
        .req(req), .resp_q(resp_q), .resp_valid_q(resp_valid_q));
    cmad_mem_model mem (.clk(clk), .reset_n(reset_n),
        .resp_valid_q(resp_valid_q), .resp_q(resp_q),
        .bad_cnt(bad_cnt), .hit_cnt(hit_cnt));

    initial begin
        forever #5 clk = ~clk;
    end

    // Expected decode of one request
    function automatic cmad_resp_t exp_resp(cmad_req_t r);
        cmad_resp_t e;
        logic [15:0] ca;
        logic ext;
        logic code;
        logic bad;
        e = '0;
        ca = (r.base_pc ? r.pc : r.data_pointer_reg) + {8'h00, r.acc};
        ext = r.mode == MD_EXT_DIRECT || r.mode == MD_EXT_INDIRECT;
        code = r.mode == MD_CODE_INDIRECT;
        bad = r.mode > MD_CODE_INDIRECT || ext != (r.iclass == IC_EXT_MOVE)
            || code != (r.iclass == IC_CODE_MOVE)
            || (r.iclass == IC_BOOLEAN && r.mode != MD_DIRECT)
            || (r.write && (r.mode == MD_IMMEDIATE || code))
            || (r.mode == MD_IMMEDIATE && r.pc >= 16'hf800)
            || (code && ca >= 16'hf800);
        e.write = r.write;
        e.wdata = r.wdata;
        e.space = SP_FLASH;
        e.addr = ca;
        case (r.mode)
            MD_IMMEDIATE: e.addr = r.pc;
            MD_DIRECT: begin
                e.space = r.addr[7] ? SP_SPECIAL : SP_LOW_RAM;
                e.addr = {8'h00, r.addr};
                if (r.iclass == IC_BOOLEAN) begin
                    e.bit_en = 1'b1;
                    e.bit_sel = r.addr[2:0];
                    e.addr = r.addr[7] ? {8'h00, r.addr[7:3], 3'b000}
                        : 16'h0020 + {12'h000, r.addr[6:3]};
                end
            end
            MD_INDIRECT: begin
                e.space = r.pointer_register_zero[7] ? SP_UPPER_RAM : SP_LOW_RAM;
                e.addr = {8'h00, r.pointer_register_zero};
            end
            MD_EXT_DIRECT: begin
                e.space = SP_EXT_RAM;
                e.addr = {5'h00, r.data_pointer_reg[10:0]};
            end
            MD_EXT_INDIRECT: begin
                e.space = SP_EXT_RAM;
                e.addr = {8'h00, r.pointer_register_zero};
            end
            default: ;
        endcase
        if (bad) begin
            e = '0;
            e.err = 1'b1;
        end
        return e;
    endfunction

    task automatic cmp_space(string n, cmad_space_t e, cmad_space_t s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %0d seen %0d", n, e, s);
        end
    endtask

    task automatic cmp_addr(string n, logic [15:0] e, logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic cmp_flag(string n, logic e, logic s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %b seen %b", n, e, s);
        end
    endtask

    // One request with random side fields, key fields from the caller
    task automatic go(logic [2:0] m, cmad_iclass_t c, logic [15:0] a,
                      logic [7:0] x);
        cmad_req_t r;
        logic [95:0] t;
        t = {$random(seed), $random(seed), $random(seed)};
        r = t[70:0];
        r.mode = cmad_mode_t'(m);
        r.iclass = c;
        r.addr = a[7:0];
        r.pointer_register_zero = a[7:0];
        r.data_pointer_reg = a;
        r.pc = a;
        r.acc = x;
        @(posedge clk);
        req <= r;
        req_valid <= 1'b1;
    endtask

    // Expectation follows each taken request by one edge
    always @(posedge clk) begin
        exp_q <= exp_resp(req);
        expv_q <= req_valid && reset_n;
    end

    // Outputs looked at mid-cycle, once settled
    always @(negedge clk) begin
        if (reset_n) begin
            cmp_flag("valid", expv_q, resp_valid_q);
            if (expv_q) begin
                cmp_space("space", exp_q.space, resp_q.space);
                cmp_addr("addr", exp_q.addr, resp_q.addr);
                cmp_flag("err", exp_q.err, resp_q.err);
                cmp_flag("write", exp_q.write, resp_q.write);
                if (!exp_q.err) begin
                    cmp_flag("bit_en", exp_q.bit_en, resp_q.bit_en);
                    cmp_addr("bit_sel", {13'h0000, exp_q.bit_sel},
                        {13'h0000, resp_q.bit_sel});
                end
            end else begin
                cmp_space("idle", SP_NONE, resp_q.space);
            end
        end
    end

    task automatic finish_test();
        $display("Checked %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        logic [15:0] pa [4];
        logic [31:0] rv;
        cmad_iclass_t c;
        pa = '{16'h007f, 16'h0080, 16'h00ff, 16'hffff};
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        // Boundary addresses in every mode, back to back
        foreach (pa[i]) begin
            go(3'd1, IC_GENERAL, pa[i], 8'h00);
            go(3'd2, IC_GENERAL, pa[i], 8'h00);
            go(3'd1, IC_BOOLEAN, pa[i], 8'h00);
            go(3'd3, IC_EXT_MOVE, pa[i], 8'h00);
            go(3'd4, IC_EXT_MOVE, pa[i], 8'h00);
            go(3'd5, IC_CODE_MOVE, pa[i], 8'h02);
            go(3'd0, IC_GENERAL, pa[i], 8'h00);
        end
        go(3'd5, IC_CODE_MOVE, 16'hf7ff, 8'h00);
        go(3'd5, IC_CODE_MOVE, 16'hf7ff, 8'h01);
        go(3'd3, IC_GENERAL, 16'h0100, 8'h00);
        go(3'd1, IC_EXT_MOVE, 16'h0010, 8'h00);
        go(3'd5, IC_GENERAL, 16'h8002, 8'h00);
        go(3'd6, IC_GENERAL, 16'h0010, 8'h00);
        go(3'd7, IC_EXT_MOVE, 16'h0010, 8'h00);
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (2) @(posedge clk);
        // Random traffic, classes mostly matched to the mode
        repeat (400) begin
            rv = $random(seed);
            c = (rv[2:0] == 3'd3 || rv[2:0] == 3'd4) ? IC_EXT_MOVE
                : (rv[2:0] == 3'd5) ? IC_CODE_MOVE
                : (rv[2:0] == 3'd1 && rv[3]) ? IC_BOOLEAN : IC_GENERAL;
            if (rv[7:4] == 4'h0) c = cmad_iclass_t'(rv[9:8]);
            go(rv[2:0], c, rv[31:16], rv[15:8]);
        end
        // Reset in mid-run clears the outputs
        @(posedge clk);
        reset_n <= 1'b0;
        @(negedge clk);
        cmp_flag("rst_valid", 1'b0, resp_valid_q);
        cmp_space("rst_space", SP_NONE, resp_q.space);
        @(posedge clk);
        reset_n <= 1'b1;
        go(3'd2, IC_GENERAL, 16'h0082, 8'h00);
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (2) @(posedge clk);
        cmp_addr("offchip", 16'h0000, bad_cnt[15:0]);
        cmp_flag("mem_hits", 1'b1, hit_cnt > 0);
        finish_test();
    end
endmodule // core_memory_address_decode_tb
